// File: boot_link_consts.svh
// constants for the serial boot loader link
`ifndef BOOT_LINK_CONSTS_SVH
`define BOOT_LINK_CONSTS_SVH
`define SYNC_BYTE 8'h55
`define ACK_BYTE 8'hcc
`define NAK_BYTE 8'h33
`define MIN_OVERSAMPLE 16
`define SYNC_SPAN_BITS 18
`define DIV_W 16
`define LEN_W 8
`endif

// File: boot_link_pkg.sv
// types for the serial boot loader link
`default_nettype none
package boot_link_pkg;
  typedef enum logic [1:0] {PORT_NONE = 2'b00, PORT_ASYNC = 2'b01, PORT_SYNC = 2'b11} port_sel_t;
  typedef enum logic [2:0] {
    AB_IDLE = 3'b000, AB_MEAS = 3'b001, AB_DONE = 3'b011
  } baud_state_t;
  typedef enum logic [2:0] {
    PK_IDLE = 3'b000, PK_SUM = 3'b001, PK_DATA = 3'b011, PK_ANS = 3'b010
  } pkt_state_t;
endpackage
`default_nettype wire

// File: boot_async_tx.sv
// asynchronous byte transmitter, 8 data bits, no parity, one stop bit
`timescale 1ns/100ps
`default_nettype none
module boot_async_tx
  import boot_link_pkg::*;
#(
  parameter int DIV_W = 16
)
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [DIV_W-1:0] i_bit_div,
  input wire logic i_start,
  input wire logic [7:0] i_data,
  output logic o_txd,
  output logic o_busy
);
  logic [DIV_W-1:0] cnt_r, cnt_nxt;
  logic [9:0] shf_r, shf_nxt;
  logic [3:0] bits_r, bits_nxt;
  logic txd_r, txd_nxt;
  logic busy_r, busy_nxt;
  always_comb
  begin
    cnt_nxt = cnt_r;
    shf_nxt = shf_r;
    bits_nxt = bits_r;
    txd_nxt = txd_r;
    busy_nxt = busy_r;
    if (!busy_r)
    begin
      if (i_start)
      begin
        shf_nxt = {1'b1, i_data, 1'b0};
        bits_nxt = 4'h0;
        cnt_nxt = '0;
        busy_nxt = 1'b1;
        txd_nxt = 1'b0;
      end
    end
    else if (cnt_r + 1'b1 >= i_bit_div)
    begin
      cnt_nxt = '0;
      if (bits_r == 4'h9)
      begin
        busy_nxt = 1'b0;
        txd_nxt = 1'b1;
      end
      else
      begin
        bits_nxt = bits_r + 4'h1;
        shf_nxt = {1'b1, shf_r[9:1]};
        txd_nxt = shf_r[1];
      end
    end
    else
    begin
      cnt_nxt = cnt_r + 1'b1;
    end
  end
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      cnt_r <= '0;
      shf_r <= 10'h3ff;
      bits_r <= 4'h0;
      txd_r <= 1'b1;
      busy_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      shf_r <= shf_nxt;
      bits_r <= bits_nxt;
      txd_r <= txd_nxt;
      busy_r <= busy_nxt;
    end
  end
  assign o_txd = txd_r;
  assign o_busy = busy_r;
endmodule
`default_nettype wire

// File: boot_link.sv
// serial boot loader link: port selection, baud detection, packet framing
// Notes on behaviour
// - first port used stays selected; other port ignored until reset
// - same packet framing and answers on either port
// - runs on the crystal clock only; no pll
// - async frames are 8 data bits, no parity, one stop bit
// - async bit time never shorter than thirty-two clocks
// - measure sync pulses; set tx and rx divisors to host rate
// - after detection send one 0xcc at the detected rate
// - sync port is spi mode 3: idle high, sample second edge
// - host is master and drives clock; device does no rate detection
// - packet: length byte (total), sum byte, then payload
// - sum byte is modulo-256 sum of payload only
// - answer 0xcc when good, 0x33 when bad
// - leading zero bytes skipped before packet start
`timescale 1ns/100ps
`default_nettype none
`include "boot_link_consts.svh"
module boot_link
  import boot_link_pkg::*;
#(
  parameter int DIV_W = `DIV_W
)
(
  input wire logic i_clk, // crystal clock
  input wire logic i_srst,
  input wire logic i_rxd,
  output logic o_txd,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_mosi,
  output logic o_miso,
  output logic o_miso_oe,
  output logic [1:0] o_port,
  output logic o_synced,
  output logic o_byte_valid,
  output logic [7:0] o_byte,
  output logic o_pkt_start,
  output logic o_pkt_good,
  output logic o_pkt_bad
);
  ////////////////////////////////////////////////////////////////////////
  // input edge detection (inputs synchronous to i_clk)
  logic rxd_d_r, sclk_d_r;
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      rxd_d_r <= 1'b1;
      sclk_d_r <= 1'b1;
    end
    else
    begin
      rxd_d_r <= i_rxd;
      sclk_d_r <= i_sclk;
    end
  end
  wire logic rxd_fall = rxd_d_r & ~i_rxd;
  wire logic sclk_rise = ~sclk_d_r & i_sclk & ~i_cs_n;
  wire logic sclk_fall = sclk_d_r & ~i_sclk & ~i_cs_n;
  ////////////////////////////////////////////////////////////////////////
  // baud detection: 0x55 0x55 gives 10 falling edges; first to last is 18 bits
  port_sel_t port_r, port_nxt;
  baud_state_t ab_r, ab_nxt;
  logic [DIV_W+4:0] meas_r, meas_nxt;
  logic [3:0] edges_r, edges_nxt;
  logic [DIV_W-1:0] div_r, div_nxt;
  logic ack_go_r, ack_go_nxt;
  logic [DIV_W+4:0] meas_div;
  always_comb
  begin
    ab_nxt = ab_r;
    meas_nxt = meas_r;
    edges_nxt = edges_r;
    div_nxt = div_r;
    ack_go_nxt = 1'b0;
    meas_div = meas_r / (DIV_W+5)'(`SYNC_SPAN_BITS);
    case (ab_r)
      AB_IDLE:
      begin
        if (rxd_fall && port_r != PORT_SYNC)
        begin
          ab_nxt = AB_MEAS;
          meas_nxt = '0;
          edges_nxt = 4'h1;
        end
      end
      AB_MEAS:
      begin
        meas_nxt = meas_r + 1'b1;
        // spi won the race while a pattern was half measured
        if (port_r == PORT_SYNC)
        begin
          ab_nxt = AB_IDLE;
        end
        else if (rxd_fall)
        begin
          edges_nxt = edges_r + 4'h1;
          if (edges_r == 4'h9)
          begin
            if (meas_div >= (DIV_W+5)'(`MIN_OVERSAMPLE * 2))
            begin
              div_nxt = meas_div[DIV_W-1:0];
              ab_nxt = AB_DONE;
              ack_go_nxt = 1'b1;
            end
            else
            begin
              ab_nxt = AB_IDLE;
            end
          end
        end
        else if (&meas_r)
        begin
          ab_nxt = AB_IDLE; // too slow: wait for host to resend
        end
      end
      AB_DONE:
      begin
        ab_nxt = AB_DONE;
      end
      default:
      begin
        ab_nxt = AB_IDLE;
      end
    endcase
  end
  ////////////////////////////////////////////////////////////////////////
  // async receiver, mid-bit sampling at the detected divisor
  logic [DIV_W-1:0] rc_r, rc_nxt;
  logic [3:0] rb_r, rb_nxt;
  logic [7:0] rsh_r, rsh_nxt;
  logic ract_r, ract_nxt;
  logic rdone;
  always_comb
  begin
    rc_nxt = rc_r;
    rb_nxt = rb_r;
    rsh_nxt = rsh_r;
    ract_nxt = ract_r;
    rdone = 1'b0;
    if (!ract_r)
    begin
      if (rxd_fall && ab_r == AB_DONE && port_r == PORT_ASYNC)
      begin
        ract_nxt = 1'b1;
        rb_nxt = 4'h0;
        rc_nxt = div_r >> 1;
      end
    end
    else if (rc_r + 1'b1 >= div_r)
    begin
      rc_nxt = '0;
      rb_nxt = rb_r + 4'h1;
      if (rb_r >= 4'h1 && rb_r <= 4'h8)
        rsh_nxt = {i_rxd, rsh_r[7:1]};
      if (rb_r == 4'h9)
      begin
        ract_nxt = 1'b0;
        rdone = i_rxd; // stop bit must be high
      end
    end
    else
    begin
      rc_nxt = rc_r + 1'b1;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // spi slave mode 3: drive on falling edge, capture on rising edge
  logic [2:0] sb_r, sb_nxt;
  logic [7:0] ssh_r, ssh_nxt;
  logic [7:0] stx_r, stx_nxt;
  logic miso_r, miso_nxt;
  logic sdone;
  always_comb
  begin
    sb_nxt = sb_r;
    ssh_nxt = ssh_r;
    stx_nxt = stx_r;
    miso_nxt = miso_r;
    sdone = 1'b0;
    if (i_cs_n || port_r == PORT_ASYNC)
    begin
      sb_nxt = 3'h0;
    end
    else
    begin
      if (sclk_fall)
      begin
        miso_nxt = stx_r[7];
        stx_nxt = {stx_r[6:0], 1'b0};
      end
      if (sclk_rise)
      begin
        ssh_nxt = {ssh_r[6:0], i_mosi};
        sb_nxt = sb_r + 3'h1;
        sdone = (sb_r == 3'h7);
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // port selection and unified byte stream
  logic in_valid;
  logic [7:0] in_byte;
  always_comb
  begin
    port_nxt = port_r;
    if (port_r == PORT_NONE)
    begin
      if (ack_go_r)
        port_nxt = PORT_ASYNC;
      else if (sdone && {ssh_r[6:0], i_mosi} != 8'h00)
        port_nxt = PORT_SYNC;
    end
    in_valid = 1'b0;
    in_byte = 8'h00;
    if (port_r == PORT_ASYNC && rdone)
    begin
      in_valid = 1'b1;
      in_byte = rsh_nxt;
    end
    else if (port_nxt == PORT_SYNC && sdone)
    begin
      in_valid = 1'b1;
      in_byte = {ssh_r[6:0], i_mosi};
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // packet framing and checking
  pkt_state_t pk_r, pk_nxt;
  logic [7:0] len_r, len_nxt, sum_r, sum_nxt, acc_r, acc_nxt, cnt_r, cnt_nxt;
  logic [7:0] ans_r, ans_nxt;
  logic tx_go, start_nxt, good_nxt, bad_nxt;
  logic tx_busy;
  logic oe_r, synced_r;
  always_comb
  begin
    pk_nxt = pk_r;
    len_nxt = len_r;
    sum_nxt = sum_r;
    acc_nxt = acc_r;
    cnt_nxt = cnt_r;
    ans_nxt = ans_r;
    tx_go = 1'b0;
    start_nxt = 1'b0;
    good_nxt = 1'b0;
    bad_nxt = 1'b0;
    case (pk_r)
      PK_IDLE:
      begin
        if (in_valid && in_byte != 8'h00)
        begin
          len_nxt = in_byte;
          acc_nxt = 8'h00;
          cnt_nxt = 8'h01;
          start_nxt = 1'b1;
          pk_nxt = PK_SUM;
        end
      end
      PK_SUM:
      begin
        if (in_valid)
        begin
          sum_nxt = in_byte;
          cnt_nxt = 8'h02;
          pk_nxt = (len_r <= 8'h02) ? PK_ANS : PK_DATA;
        end
      end
      PK_DATA:
      begin
        if (in_valid)
        begin
          acc_nxt = acc_r + in_byte;
          cnt_nxt = cnt_r + 8'h01;
          if (cnt_r + 8'h01 >= len_r)
            pk_nxt = PK_ANS;
        end
      end
      PK_ANS:
      begin
        if (len_r >= 8'h03 && acc_r == sum_r)
        begin
          ans_nxt = `ACK_BYTE;
          good_nxt = 1'b1;
        end
        else
        begin
          ans_nxt = `NAK_BYTE;
          bad_nxt = 1'b1;
        end
        tx_go = 1'b1;
        pk_nxt = PK_IDLE;
      end
      default:
      begin
        pk_nxt = PK_IDLE;
      end
    endcase
  end
  ////////////////////////////////////////////////////////////////////////
  // answers: async goes to the transmitter, sync loads the spi shifter
  logic [7:0] tx_byte;
  logic tx_start;
  always_comb
  begin
    tx_start = 1'b0;
    tx_byte = `ACK_BYTE;
    if (ack_go_r)
      tx_start = 1'b1;
    else if (pk_r == PK_ANS && port_r == PORT_ASYNC && !tx_busy)
    begin
      tx_start = 1'b1;
      tx_byte = ans_nxt;
    end
  end
  // late answer on a busy transmitter is dropped; host will resend
  boot_async_tx #(.DIV_W(DIV_W)) u_tx (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_bit_div(div_nxt),
    .i_start(tx_start),
    .i_data(tx_byte),
    .o_txd(o_txd),
    .o_busy(tx_busy)
  );
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      port_r <= PORT_NONE;
      ab_r <= AB_IDLE;
      meas_r <= '0;
      edges_r <= 4'h0;
      div_r <= DIV_W'(`MIN_OVERSAMPLE);
      ack_go_r <= 1'b0;
      rc_r <= '0;
      rb_r <= 4'h0;
      rsh_r <= 8'h00;
      ract_r <= 1'b0;
      sb_r <= 3'h0;
      ssh_r <= 8'h00;
      stx_r <= 8'h00;
      miso_r <= 1'b1;
      pk_r <= PK_IDLE;
      len_r <= 8'h00;
      sum_r <= 8'h00;
      acc_r <= 8'h00;
      cnt_r <= 8'h00;
      ans_r <= 8'h00;
      o_byte_valid <= 1'b0;
      o_byte <= 8'h00;
      o_pkt_start <= 1'b0;
      o_pkt_good <= 1'b0;
      o_pkt_bad <= 1'b0;
      oe_r <= 1'b0;
      synced_r <= 1'b0;
    end
    else
    begin
      port_r <= port_nxt;
      ab_r <= ab_nxt;
      meas_r <= meas_nxt;
      edges_r <= edges_nxt;
      div_r <= div_nxt;
      ack_go_r <= ack_go_nxt;
      rc_r <= rc_nxt;
      rb_r <= rb_nxt;
      rsh_r <= rsh_nxt;
      ract_r <= ract_nxt;
      sb_r <= sb_nxt;
      ssh_r <= ssh_nxt;
      stx_r <= (tx_go && port_r == PORT_SYNC) ? ans_nxt : stx_nxt;
      miso_r <= miso_nxt;
      pk_r <= pk_nxt;
      len_r <= len_nxt;
      sum_r <= sum_nxt;
      acc_r <= acc_nxt;
      cnt_r <= cnt_nxt;
      ans_r <= ans_nxt;
      o_byte_valid <= in_valid && pk_r != PK_IDLE;
      o_byte <= in_byte;
      o_pkt_start <= start_nxt;
      o_pkt_good <= good_nxt;
      o_pkt_bad <= bad_nxt;
      oe_r <= ~i_cs_n && port_nxt == PORT_SYNC;
      synced_r <= (ab_nxt == AB_DONE);
    end
  end
  assign o_miso = miso_r;
  // enable trails chip select by one clock so that it comes from a flop
  assign o_miso_oe = oe_r;
  assign o_port = port_r;
  assign o_synced = synced_r;
endmodule
`default_nettype wire

// File: boot_link_asserts.sv
// concurrent checks on the boot link top ports
`timescale 1ns/100ps
`default_nettype none
module boot_link_asserts
  import boot_link_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_cs_n,
  input wire logic o_txd,
  input wire logic o_miso_oe,
  input wire logic [1:0] o_port,
  input wire logic o_synced,
  input wire logic o_pkt_good,
  input wire logic o_pkt_bad
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);
  ////////////////////////////////////////////////////////////////
  port_held_a: assert property (o_port != PORT_NONE |=> $stable(o_port))
    else $error("selected port changed");
  reset_idle_a: assert property ($fell(i_srst) |-> o_port == PORT_NONE && o_txd)
    else $error("port or txd wrong after reset");
  sync_quiet_a: assert property (o_port == PORT_SYNC |-> o_txd)
    else $error("async line active while sync port selected");
  oe_map_a: assert property (o_miso_oe == (!$past(i_cs_n) && o_port == PORT_SYNC))
    else $error("miso enable wrong");
  pkt_excl_a: assert property (!(o_pkt_good && o_pkt_bad))
    else $error("good and bad together");
  good_pulse_a: assert property (o_pkt_good |=> !o_pkt_good)
    else $error("good pulse too long");
  sync_sel_a: assert property ($rose(o_synced) |-> ##[0:2] o_port == PORT_ASYNC)
    else $error("sync did not select async port");
  ack_start_a: assert property ($rose(o_synced) |-> ##[0:4] !o_txd)
    else $error("no answer after sync");
  // start bit must cover at least sixteen clocks
  start_len_a: assert property ($fell(o_txd) |-> !o_txd [*8] ##1 !o_txd [*8])
    else $error("async bit too short");
  cover property (o_pkt_good && o_port == PORT_ASYNC);
  cover property (o_pkt_good && o_port == PORT_SYNC);
  cover property (o_pkt_bad);
endmodule
bind boot_link boot_link_asserts chk (.i_clk(i_clk), .i_srst(i_srst), .i_cs_n(i_cs_n),
  .o_txd(o_txd), .o_miso_oe(o_miso_oe), .o_port(o_port), .o_synced(o_synced),
  .o_pkt_good(o_pkt_good), .o_pkt_bad(o_pkt_bad));
`default_nettype wire

// File: host_model.sv
// host side model: async sender and receiver, spi mode 3 master
`timescale 1ns/100ps
`default_nettype none
module host_model #(
  parameter int BIT = 40,
  parameter int HALF = 8
)
(
  input wire logic i_clk,
  input wire logic i_txd,
  input wire logic i_miso,
  output logic o_rxd,
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_mosi
);
  initial
  begin
    o_rxd = 1'b1;
    o_sclk = 1'b1;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
  end
  ////////////////////////////////////////////////////////////////
  // bit time of BIT clocks, kept at 32 or more
  task automatic uart_send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    @(posedge i_clk);
    for (int i = 0; i < 10; i++)
    begin
      o_rxd <= f[i];
      repeat (BIT) @(posedge i_clk);
    end
  endtask
  task automatic uart_recv(output logic [7:0] b, output logic ok);
    ok = 1'b0;
    b = 8'h00;
    for (int n = 0; n < 4000 && i_txd !== 1'b0; n++)
      @(negedge i_clk);
    if (i_txd === 1'b0)
    begin
      ok = 1'b1;
      repeat (BIT + BIT / 2) @(negedge i_clk);
      for (int i = 0; i < 8; i++)
      begin
        b[i] = i_txd;
        repeat (BIT) @(negedge i_clk);
      end
    end
  endtask
  // host is master and makes the clock, msb first
  task automatic spi_xfer(input logic [7:0] d, output logic [7:0] r);
    @(posedge i_clk);
    o_cs_n <= 1'b0;
    repeat (HALF) @(posedge i_clk);
    for (int i = 7; i >= 0; i--)
    begin
      o_sclk <= 1'b0;
      o_mosi <= d[i];
      repeat (HALF) @(posedge i_clk);
      r[i] = i_miso;
      o_sclk <= 1'b1;
      repeat (HALF) @(posedge i_clk);
    end
    o_cs_n <= 1'b1;
    // released data line shows no stale level
    o_mosi <= ~o_mosi;
  endtask
endmodule
`default_nettype wire

// File: tb.sv
// self-checking bench for the serial boot loader link
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam int BIT = 40;
  logic i_clk, i_srst, rxd, sclk, cs_n, mosi;
  logic txd, miso, miso_oe, synced, pkt_good, pkt_bad;
  logic [1:0] port;
  logic byte_valid, pkt_start;
  logic [7:0] rx_byte, last_byte;
  int starts = 0;
  int errors, checked;
  // rows: packet bytes, byte count, expected answer
  logic [7:0] rows [5][4] = '{'{8'h03, 8'h20, 8'h20, 8'h00}, '{8'h03, 8'h21, 8'h20, 8'h00},
    '{8'h04, 8'h30, 8'h10, 8'h20}, '{8'h00, 8'h03, 8'h05, 8'h05}, '{8'h02, 8'h00, 8'h00, 8'h00}};
  int lens [5] = '{3, 3, 4, 4, 2};
  logic [7:0] answers [5] = '{8'hcc, 8'h33, 8'hcc, 8'hcc, 8'h33};
  boot_link uut (.i_clk(i_clk), .i_srst(i_srst), .i_rxd(rxd), .o_txd(txd), .i_sclk(sclk),
    .i_cs_n(cs_n), .i_mosi(mosi), .o_miso(miso), .o_miso_oe(miso_oe), .o_port(port),
    .o_synced(synced), .o_byte_valid(byte_valid), .o_byte(rx_byte), .o_pkt_start(pkt_start),
    .o_pkt_good(pkt_good),
    .o_pkt_bad(pkt_bad));
  host_model #(.BIT(BIT), .HALF(8)) host (.i_clk(i_clk), .i_txd(txd), .i_miso(miso),
    .o_rxd(rxd), .o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi));
  ////////////////////////////////////////////////////////////////
  initial
  begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  // count packet starts and keep the last packet byte shown
  always @(negedge i_clk)
  begin
    if (pkt_start === 1'b1)
      starts++;
    if (byte_valid === 1'b1)
      last_byte = rx_byte;
  end
  initial
  begin
    repeat (60000) @(posedge i_clk);
    errors++;
    close_out();
  end
  task automatic close_out();
    if (errors == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic watch(output logic g, output logic b);
    g = 1'b0;
    b = 1'b0;
    for (int n = 0; n < 3000 && !(g | b); n++)
    begin
      @(negedge i_clk);
      g = pkt_good;
      b = pkt_bad;
    end
  endtask
  task automatic sync_async(output logic [7:0] d, output logic ok);
    fork
      begin
        host.uart_send(8'h55);
        host.uart_send(8'h55);
      end
      host.uart_recv(d, ok);
    join
  endtask
  task automatic pkt_async(input int r);
    logic g, b, ok;
    logic [7:0] ans;
    int s0;
    s0 = starts;
    fork
      for (int j = 0; j < lens[r]; j++)
        host.uart_send(rows[r][j]);
      watch(g, b);
      host.uart_recv(ans, ok);
    join
    check({6'h0, g, b}, {6'h0, answers[r] == 8'hcc, answers[r] == 8'h33});
    check(ans, answers[r]);
    check(8'(starts - s0), 8'h01);
    check(last_byte, rows[r][lens[r] - 1]);
    repeat (2 * BIT) @(posedge i_clk);
  endtask
  task automatic spi_pkt(output logic g, output logic b);
    logic [7:0] r;
    fork
      begin
        host.spi_xfer(8'h00, r);
        host.spi_xfer(8'h03, r);
        host.spi_xfer(8'h20, r);
        host.spi_xfer(8'h20, r);
      end
      watch(g, b);
    join
  endtask
  task automatic reset_dut();
    @(posedge i_clk);
    i_srst <= 1'b1;
    repeat (4) @(posedge i_clk);
    i_srst <= 1'b0;
    @(negedge i_clk);
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    logic g, b, ok;
    logic [7:0] d;
    int s0;
    errors = 0;
    checked = 0;
    i_srst = 1'b1;
    reset_dut();
    check({5'h0, txd, port}, 8'h04);
    sync_async(d, ok);
    if (ok !== 1'b1)
      sync_async(d, ok);
    check(d, 8'hcc);
    check({5'h0, synced, port}, 8'h05);
    for (int r = 0; r < 5; r++)
      pkt_async(r);
    // spi traffic must not count once async is chosen
    s0 = starts;
    spi_pkt(g, b);
    check({4'h0, g, b, port}, 8'h01);
    check(8'(starts - s0), 8'h00);
    reset_dut();
    check({6'h0, port}, 8'h00);
    s0 = starts;
    spi_pkt(g, b);
    check({4'h0, g, b, port}, 8'h0b);
    check(8'(starts - s0), 8'h01);
    check(last_byte, 8'h20);
    host.spi_xfer(8'h00, d);
    check(d, 8'hcc);
    sync_async(d, ok);
    check({6'h0, ok, synced}, 8'h00);
    close_out();
  end
endmodule
`default_nettype wire
